// File: inc/slc_pkg.sv
// shared constants and types of the stored-control word-element core
// assumes a single core clock; all pins are handled inside the core
package slc_pkg;
    localparam int WORD_W    = 15;      // one word element
    localparam int ADDR_W    = 13;      // core store address width
    localparam int MEM_WORDS = 8192;    // core store depth in elements
    localparam int CH_W      = 30;      // parallel channel word
    localparam int SYNC_W    = 18;      // irq, dio, ack and 15 aux bits
    localparam logic [12:0] RESET_PC  = 13'h0000;
    localparam logic [14:0] ACC_RESET = 15'h0000;
    localparam logic [12:0] ADDR_STEP = 13'h0001;
    localparam logic [12:0] PAIR_STEP = 13'h0002;
    localparam logic [14:0] CNT_STEP  = 15'h0001;

    // control word operation codes
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_LDA = 4'h1, OP_STA = 4'h2, OP_ADD = 4'h3,
        OP_SHF = 4'h4, OP_LDX = 4'h5, OP_LDI = 4'h6, OP_JMP = 4'h7,
        OP_BLK = 4'h8, OP_BIO = 4'h9, OP_TLU = 4'hA, OP_MAT = 4'hB,
        OP_AUX = 4'hC, OP_RET = 4'hD
    } op_e;

    // comparison criteria for look-up and match
    typedef enum logic [1:0] {
        CMP_EQ = 2'h0, CMP_NE = 2'h1, CMP_GT = 2'h2, CMP_LT = 2'h3
    } cmp_e;

    // layout of one control word element
    typedef struct packed {
        op_e        op;
        logic [3:0] rsv;
        logic       sel;    // shift left / output direction
        logic [3:0] amt;    // shift distance
        cmp_e       cond;
    } cw_s;

    // outward side of the 30-bit channel
    typedef struct packed {
        logic        req;
        logic        dir;   // 1: core to peripheral
        logic [29:0] data;
    } chan_out_s;

    // operand elements that follow each control word
    function automatic logic [2:0] opnd_count(op_e op);
        case (op)
            OP_LDA, OP_STA, OP_ADD, OP_LDI, OP_JMP: opnd_count = 3'h1;
            OP_LDX, OP_BIO:                         opnd_count = 3'h2;
            OP_BLK:                                 opnd_count = 3'h3;
            OP_TLU, OP_MAT:                         opnd_count = 3'h4;
            default:                                opnd_count = 3'h0;
        endcase
    endfunction
endpackage

// File: design/stored_logic_core.sv
// stored-control core built from 15-bit word elements, with block
// operations, external requests and the two parallel output paths
// assumes peripherals hold channel data until they see req drop
`timescale 1ns/1ns
// Overview of operation
// R1: datapath, store and registers are one 15-bit element wide
// R2: add-with-link chains elements into 30- and 45-bit words
// R3: core store holds 8192 elements, addressed by 13 bits
// R4: each control word does one simple wired operation
// R5: any store word serves as index or indirect address
// R6: external request suspends work and runs device-named service
// R7: device sets transfer length by holding its data request
// R8: suspended computation resumes with results intact
// R9: block copy moves contiguous elements source to destination
// R10: block channel transfer count comes from the program
// R11: look-up scans a table, branching on condition or running out
// R12: match branches at the first pair failing the condition
// R13: four criteria: equal, not equal, greater, less
// R14: channel moves full 30-bit words in parallel
// R15: separate 15-bit register serves slow peripherals
// R16: peripherals open by interrupt and pace every word
// R17: every control word ends by fetching the next one
// R18: context saved on accepting a request, restored on return
module stored_logic_core (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // external requests
    input  wire logic                irqReq,
    input  wire logic [12:0]         irqVec,
    input  wire logic                dioReq,
    input  wire logic                dioDir,
    input  wire logic [12:0]         dioAddr,
    // 30-bit channel
    input  wire logic                chAck,
    input  wire logic [29:0]         chDataIn,
    output slc_pkg::chan_out_s       chOut,
    // 15-bit register
    input  wire logic [14:0]         auxIn,
    output logic      [14:0]         auxOut,
    output logic                     auxStrobe,
    // status
    output logic                     inService
);
    typedef enum logic [3:0] {
        S_FETCH, S_OPND, S_EXEC, S_BLK, S_SRCH,
        S_CHLOAD, S_CHWAIT, S_CHLO, S_CHDROP
    } state_e;

    logic [14:0]        mem [slc_pkg::MEM_WORDS];
    state_e             state_r;
    logic [12:0]        pc_r, savedPc_r, p0_r, p1_r;
    logic [14:0]        acc_r, savedAcc_r, cnt_r;
    logic               link_r, savedLink_r;
    slc_pkg::cw_s       cw_r;
    logic [14:0]        opr_r [4];
    logic [1:0]         k_r;
    logic               dioMode_r, inSvc_r, irqPend_r, irqPrev_r;
    slc_pkg::chan_out_s chOut_r;
    logic [14:0]        auxOut_r;
    logic [14:0]        loHold_r;
    logic               auxStrobe_r;
    logic [17:0]        s1_r, s2_r, s3_r, stable_r;
    logic               irqS, dioS, ackS, irqRise, irqTake, dioTake;
    logic [14:0]        auxS, rdA0, rdIdx, rdInd;
    logic [15:0]        addSum;
    logic               hit, chanDone, we;
    logic [12:0]        wa;
    logic [14:0]        wd;

    assign chOut     = chOut_r;
    assign auxOut    = auxOut_r;
    assign auxStrobe = auxStrobe_r;
    assign inService = inSvc_r;

    // three-stage pin sampling; a bit changes once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            stable_r <= '0;
        end else begin
            s1_r     <= {irqReq, dioReq, chAck, auxIn};
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= (s2_r & ~(s2_r ^ s3_r)) | (stable_r & (s2_r ^ s3_r));
        end
    end
    assign irqS = stable_r[17];
    assign dioS = stable_r[16];
    assign ackS = stable_r[15];
    assign auxS = stable_r[14:0];

    // requests are taken only between control words, data first
    assign dioTake = state_r == S_FETCH && dioS && !inSvc_r;       // [R6]
    assign irqTake = state_r == S_FETCH && irqPend_r && !inSvc_r
                     && !dioS;                                     // [R6]
    assign irqRise = irqS && !irqPrev_r;                           // [R16]

    // pending interrupt; a new edge wins over the acceptance clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irqPrev_r <= 1'b0;
            irqPend_r <= 1'b0;
        end else begin
            irqPrev_r <= irqS;
            irqPend_r <= irqRise || (irqPend_r && !irqTake);
        end
    end

    // asynchronous reads keep every step to a single cycle
    assign rdA0   = mem[opr_r[0][12:0]];                           // [R3]
    assign rdIdx  = mem[13'(opr_r[0][12:0] + mem[opr_r[1][12:0]][12:0])];
    assign rdInd  = mem[rdA0[12:0]];                               // [R5]
    assign addSum = {1'b0, acc_r} + {1'b0, rdA0} + {15'h0000, link_r};

    // compare table or second-sequence element x against y
    function automatic logic holds(slc_pkg::cmp_e c, logic [14:0] x,
                                   logic [14:0] y);
        case (c)
            slc_pkg::CMP_EQ: holds = x == y;                       // [R13]
            slc_pkg::CMP_NE: holds = x != y;
            slc_pkg::CMP_GT: holds = x > y;
            default:         holds = x < y;
        endcase
    endfunction
    // match exits on failure, look-up on success
    assign hit = (cw_r.op == slc_pkg::OP_MAT)
               ? !holds(cw_r.cond, mem[p1_r], mem[p0_r])           // [R12]
               :  holds(cw_r.cond, mem[p1_r], mem[p0_r]);          // [R11]
    // device-led transfers end when the device drops its request, program ones at zero count
    assign chanDone = dioMode_r ? !dioS : cnt_r == 15'h0000;       // [R7]

    // single store write port shared by all writers
    always_comb begin
        we = 1'b0;
        wa = p0_r;
        wd = acc_r;
        case (state_r)
            S_EXEC: if (cw_r.op == slc_pkg::OP_STA) begin
                we = 1'b1;
                wa = opr_r[0][12:0];
            end
            S_BLK: if (cnt_r != 15'h0000) begin
                we = 1'b1;                                         // [R9]
                wa = p1_r;
                wd = mem[p0_r];
            end
            S_CHWAIT: if (ackS && !chOut_r.dir) begin
                we = 1'b1;                                         // [R14]
                wd = chDataIn[29:15];
            end
            S_CHLO: if (!chOut_r.dir) begin
                we = 1'b1;
                wa = p0_r + slc_pkg::ADDR_STEP;
                wd = loHold_r;
            end
            default: ;
        endcase
    end

    // low half is caught with the acknowledge: the peripheral may let
    // its data go as soon as it sees req drop, before the second write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            loHold_r <= '0;
        end else if (state_r == S_CHWAIT && ackS) begin
            loHold_r <= chDataIn[14:0];                            // [R14]
        end
    end

    // core store; contents are undefined until loaded over the channel
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    // sequencer, working registers and channel control
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r     <= S_FETCH;
            pc_r        <= slc_pkg::RESET_PC;
            acc_r       <= slc_pkg::ACC_RESET;
            link_r      <= 1'b0;
            savedPc_r   <= slc_pkg::RESET_PC;
            savedAcc_r  <= slc_pkg::ACC_RESET;
            savedLink_r <= 1'b0;
            cw_r        <= '0;
            opr_r       <= '{default: '0};
            k_r         <= 2'h0;
            p0_r        <= '0;
            p1_r        <= '0;
            cnt_r       <= '0;
            dioMode_r   <= 1'b0;
            inSvc_r     <= 1'b0;
            chOut_r     <= '0;
            auxOut_r    <= '0;
            auxStrobe_r <= 1'b0;
        end else begin
            auxStrobe_r <= 1'b0;
            case (state_r)
                S_FETCH: if (dioTake || irqTake) begin
                    savedPc_r   <= pc_r;                           // [R18]
                    savedAcc_r  <= acc_r;
                    savedLink_r <= link_r;
                    inSvc_r     <= 1'b1;
                    dioMode_r   <= dioTake;
                    if (dioTake) begin
                        p0_r        <= dioAddr;
                        chOut_r.dir <= dioDir;
                        state_r     <= S_CHLOAD;
                    end else begin
                        pc_r <= irqVec;                            // [R6]
                    end
                end else begin
                    cw_r    <= mem[pc_r];                          // [R17]
                    pc_r    <= pc_r + slc_pkg::ADDR_STEP;
                    k_r     <= 2'h0;
                    state_r <= (slc_pkg::opnd_count(slc_pkg::op_e'(
                               mem[pc_r][14:11])) == 3'h0) ? S_EXEC : S_OPND;
                end
                S_OPND: begin
                    opr_r[k_r] <= mem[pc_r];
                    pc_r       <= pc_r + slc_pkg::ADDR_STEP;
                    k_r        <= k_r + 2'h1;
                    if ({1'b0, k_r} + 3'h1 == slc_pkg::opnd_count(cw_r.op)) begin
                        state_r <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    state_r <= S_FETCH;                            // [R17]
                    p0_r    <= opr_r[0][12:0];
                    p1_r    <= opr_r[1][12:0];
                    cnt_r   <= opr_r[2];
                    case (cw_r.op)                                 // [R4]
                        slc_pkg::OP_LDA: begin
                            acc_r  <= rdA0;                        // [R1]
                            link_r <= 1'b0;
                        end
                        slc_pkg::OP_ADD: {link_r, acc_r} <= addSum; // [R2]
                        slc_pkg::OP_SHF: acc_r <= cw_r.sel
                                       ? acc_r << cw_r.amt
                                       : acc_r >> cw_r.amt;
                        slc_pkg::OP_LDX: acc_r <= rdIdx;           // [R5]
                        slc_pkg::OP_LDI: acc_r <= rdInd;           // [R5]
                        slc_pkg::OP_JMP: pc_r <= opr_r[0][12:0];
                        slc_pkg::OP_BLK: state_r <= S_BLK;
                        slc_pkg::OP_BIO: begin
                            cnt_r       <= opr_r[1];               // [R10]
                            dioMode_r   <= 1'b0;
                            chOut_r.dir <= cw_r.sel;
                            state_r     <= S_CHLOAD;
                        end
                        slc_pkg::OP_TLU,
                        slc_pkg::OP_MAT: state_r <= S_SRCH;
                        slc_pkg::OP_AUX: if (cw_r.sel) begin
                            auxOut_r    <= acc_r;                  // [R15]
                            auxStrobe_r <= 1'b1;
                        end else begin
                            acc_r <= auxS;
                        end
                        slc_pkg::OP_RET: begin
                            pc_r    <= savedPc_r;                  // [R8]
                            acc_r   <= savedAcc_r;
                            link_r  <= savedLink_r;
                            inSvc_r <= 1'b0;
                        end
                        default: ;
                    endcase
                end
                S_BLK: if (cnt_r == 15'h0000) begin
                    state_r <= S_FETCH;
                end else begin
                    p0_r  <= p0_r + slc_pkg::ADDR_STEP;            // [R9]
                    p1_r  <= p1_r + slc_pkg::ADDR_STEP;
                    cnt_r <= cnt_r - slc_pkg::CNT_STEP;
                end
                S_SRCH: if (cnt_r == 15'h0000) begin
                    state_r <= S_FETCH;                            // [R11]
                end else if (hit) begin
                    pc_r    <= opr_r[3][12:0];                     // [R12]
                    state_r <= S_FETCH;
                end else begin
                    p1_r  <= p1_r + slc_pkg::ADDR_STEP;
                    cnt_r <= cnt_r - slc_pkg::CNT_STEP;
                    if (cw_r.op == slc_pkg::OP_MAT) begin
                        p0_r <= p0_r + slc_pkg::ADDR_STEP;
                    end
                end
                S_CHLOAD: if (chanDone) begin
                    state_r <= S_FETCH;
                    if (dioMode_r) begin
                        pc_r    <= savedPc_r;                      // [R8]
                        acc_r   <= savedAcc_r;
                        link_r  <= savedLink_r;
                        inSvc_r <= 1'b0;
                    end
                end else begin
                    chOut_r.req <= 1'b1;                           // [R14]
                    if (chOut_r.dir) begin
                        chOut_r.data <= {mem[p0_r],
                                         mem[p0_r + slc_pkg::ADDR_STEP]};
                    end
                    state_r <= S_CHWAIT;
                end
                S_CHWAIT: if (ackS) begin
                    chOut_r.req <= 1'b0;                           // [R16]
                    state_r     <= S_CHLO;
                end
                S_CHLO: begin
                    p0_r    <= p0_r + slc_pkg::PAIR_STEP;
                    cnt_r   <= cnt_r - slc_pkg::CNT_STEP;
                    state_r <= S_CHDROP;
                end
                S_CHDROP: if (!ackS) begin
                    state_r <= S_CHLOAD;                           // [R16]
                end
                default: state_r <= S_FETCH;
            endcase
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_ack_seen;
        state_r == S_CHWAIT && ackS;
    endsequence
    sequence s_word_done;
        state_r == S_CHLO && !chOut_r.req ##1 state_r == S_CHDROP;
    endsequence

    a_exec_chains: assert property (state_r == S_EXEC && cw_r.op
        != slc_pkg::OP_BLK && cw_r.op != slc_pkg::OP_BIO && cw_r.op
        != slc_pkg::OP_TLU && cw_r.op != slc_pkg::OP_MAT
        |=> state_r == S_FETCH)                                    // [R17]
        else $error("control word did not return to fetch");
    a_add_width: assert property (state_r == S_EXEC
        && cw_r.op == slc_pkg::OP_ADD
        |=> acc_r == $past(addSum[14:0]) && link_r == $past(addSum[15]))
        else $error("element add or link carry wrong");            // [R2]
    a_index_load: assert property (state_r == S_EXEC
        && cw_r.op == slc_pkg::OP_LDX |=> acc_r == $past(rdIdx))   // [R5]
        else $error("indexed load wrong");
    a_irq_vector: assert property (irqTake
        |=> pc_r == $past(irqVec) && inSvc_r
            && savedPc_r == $past(pc_r))                           // [R6]
        else $error("interrupt entry wrong");
    a_ret_resume: assert property (state_r == S_EXEC
        && cw_r.op == slc_pkg::OP_RET
        |=> pc_r == $past(savedPc_r) && acc_r == $past(savedAcc_r)
            && !inSvc_r)                                           // [R8]
        else $error("context not restored");
    a_block_step: assert property (state_r == S_BLK && cnt_r != 15'h0000
        |=> cnt_r == $past(cnt_r) - slc_pkg::CNT_STEP
            && p1_r == $past(p1_r) + slc_pkg::ADDR_STEP)           // [R9]
        else $error("block copy step wrong");
    a_search_hit: assert property (state_r == S_SRCH && cnt_r != 15'h0000
        && hit |=> state_r == S_FETCH && pc_r == $past(opr_r[3][12:0]))
        else $error("search branch wrong");                        // [R11]
    a_chan_word: assert property (s_ack_seen |=> s_word_done)      // [R14]
        else $error("channel word handshake wrong");
    a_aux_pulse: assert property (state_r == S_EXEC
        && cw_r.op == slc_pkg::OP_AUX && cw_r.sel
        |=> auxStrobe && auxOut == $past(acc_r) ##1 !auxStrobe)    // [R15]
        else $error("aux register output wrong");
endmodule

// File: bench/chan_periph_model.sv
// peripheral on the 30-bit channel: opens transfers and paces words
// assumes the core holds req until it sees chAck, data valid with req
`timescale 1ns/1ns
module chan_periph_model (
    // clock
    input  wire logic               core_clk,
    // channel from the core
    input  wire slc_pkg::chan_out_s chOut,
    // channel answers
    output logic                    chAck,
    output logic [29:0]             chDataIn,
    // transfer request
    output logic                    dioReq,
    output logic                    dioDir,
    output logic [12:0]             dioAddr
);
    logic [29:0] inQ[$];
    logic [29:0] outQ[$];
    int          ackDelay;
    int          remaining;

    // open a device-led transfer of n words
    task automatic start_dio(input logic dir, input logic [12:0] addr,
                             input int n);
        @(posedge core_clk);
        #1;
        dioDir = dir;
        dioAddr = addr;
        remaining = n;
        dioReq = 1'b1;
    endtask

    // four-phase responder; a slow setting delays every acknowledge
    initial begin
        // idle levels at time zero
        chAck = 1'b0;
        chDataIn = 30'h00000000;
        dioReq = 1'b0;
        dioDir = 1'b0;
        dioAddr = 13'h0000;
        ackDelay = 0;
        remaining = 0;
        forever begin
            @(posedge core_clk);
            #1;
            if (chOut.req === 1'b1) begin
                repeat (ackDelay) begin
                    @(posedge core_clk);
                    #1;
                end
                if (chOut.dir === 1'b1)
                    outQ.push_back(chOut.data);
                else if (inQ.size() > 0)
                    chDataIn = inQ.pop_front();
                chAck = 1'b1;
                if (remaining > 0) begin
                    remaining--;
                    // device decides the length: drop after last word
                    if (remaining == 0)
                        dioReq = 1'b0;
                end
                while (chOut.req !== 1'b0) begin
                    @(posedge core_clk);
                    #1;
                end
                chAck = 1'b0;
                // released data must not look like the last word
                chDataIn = ~chDataIn;
            end
        end
    end
endmodule

// File: bench/tb_block_ops_and_external_io.sv
// bench for the stored-control core: program load, block ops, requests
// assumes the store is loaded only through device-led input transfers
`timescale 1ns/1ns
module tb_block_ops_and_external_io;
    logic               core_clk;
    logic               rst;
    logic               irqReq;
    logic [12:0]        irqVec;
    logic               dioReq;
    logic               dioDir;
    logic [12:0]        dioAddr;
    logic               chAck;
    logic [29:0]        chDataIn;
    slc_pkg::chan_out_s chOut;
    logic [14:0]        auxIn;
    logic [14:0]        auxOut;
    logic               auxStrobe;
    logic               inService;
    int                 num_errors;
    int                 n_checks;
    logic [14:0]        img [0:127];
    // program image, {address, element}
    localparam logic [23:0] PROG [0:67] = '{
        24'h00_0800, 24'h01_0040, 24'h02_6040, 24'h03_1800, 24'h04_0041,
        24'h05_1000, 24'h06_0050, 24'h07_4000, 24'h08_0040, 24'h09_0060,
        24'h0A_0004, 24'h0B_5000, 24'h0C_0044, 24'h0D_0040, 24'h0E_0004,
        24'h0F_0012, 24'h10_3800, 24'h11_0030, 24'h12_5001, 24'h13_0044,
        24'h14_0040, 24'h15_0004, 24'h16_0019, 24'h17_3800, 24'h18_0030,
        24'h19_5002, 24'h1A_0044, 24'h1B_0040, 24'h1C_0004, 24'h1D_0078,
        24'h1E_3800, 24'h1F_0030, 24'h20_5800, 24'h21_0040, 24'h22_0060,
        24'h23_0004, 24'h24_0030, 24'h25_4840, 24'h26_0060, 24'h27_0001,
        24'h28_3000, 24'h29_0047, 24'h2A_2004, 24'h2B_6040, 24'h2C_3800,
        24'h30_3800, 24'h31_0030, 24'h40_0123, 24'h41_7FFF, 24'h42_0456,
        24'h43_0001, 24'h44_0456, 24'h45_2AAA, 24'h46_5555, 24'h70_2800,
        24'h71_0045, 24'h72_0043, 24'h73_6040, 24'h74_6800, 24'h78_5003,
        24'h79_0044, 24'h7A_0040, 24'h7B_0004, 24'h7C_0020, 24'h7D_3800,
        24'h7E_0030, 24'h2D_002B, 24'h47_0046};

    stored_logic_core dut (
        .core_clk (core_clk), .rst (rst), .irqReq (irqReq),
        .irqVec (irqVec), .dioReq (dioReq), .dioDir (dioDir),
        .dioAddr (dioAddr), .chAck (chAck), .chDataIn (chDataIn),
        .chOut (chOut), .auxIn (auxIn), .auxOut (auxOut),
        .auxStrobe (auxStrobe), .inService (inService));
    chan_periph_model periph (
        .core_clk (core_clk), .chOut (chOut), .chAck (chAck),
        .chDataIn (chDataIn), .dioReq (dioReq), .dioDir (dioDir),
        .dioAddr (dioAddr));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [29:0] seen, input logic [29:0] exp,
                         input string msg);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // bounded wait for the next strobe, then its value and width
    task automatic wait_strobe(input logic [14:0] exp, input string msg);
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (auxStrobe !== 1'b1 && k < 3000);
        check(30'(auxStrobe), 30'h1, "strobe seen");
        check(30'(auxOut), 30'(exp), msg);
        @(posedge core_clk);
        #1;
        check(30'(auxStrobe), 30'h0, "strobe width");
    endtask

    // device-led transfer, waits until service has ended
    task automatic dio_xfer(input logic dir, input logic [12:0] addr,
                            input int n);
        int k;
        k = 0;
        periph.start_dio(dir, addr, n);
        while ((periph.remaining != 0 || inService !== 1'b0) && k < 9000)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check(30'(k < 9000), 30'h1, "transfer finished");
    endtask

    task load_program;
        foreach (img[i])
            img[i] = 15'h0000;
        foreach (PROG[i])
            img[PROG[i][22:16]] = PROG[i][14:0];
        for (int i = 0; i < 64; i++)
            periph.inQ.push_back({img[2*i], img[2*i+1]});
        dio_xfer(1'b0, 13'h0000, 64);
        // store survives reset, so a reset starts the program at 0
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check(30'(chOut), 30'h0, "channel idle in reset");
        check(30'(inService), 30'h0, "no service in reset");
        repeat (14) @(posedge core_clk);
        #1;
        rst = 1'b0;
        $display("test load_program done");
    endtask

    task run_main;
        wait_strobe(15'h0123, "first aux word");
        wait_strobe(15'h2AAA, "look-up and match path");
        check(30'(periph.outQ.size()), 30'h1, "block out count");
        check(periph.outQ[0], {15'h0123, 15'h7FFF}, "block out");
        $display("test run_main done");
    endtask

    task read_back;
        periph.ackDelay = 4;
        periph.outQ.delete();
        dio_xfer(1'b1, 13'h0060, 2);
        check(periph.outQ[0], {15'h0123, 15'h7FFF}, "copy 0");
        check(periph.outQ[1], {15'h0456, 15'h0001}, "copy 1");
        check(30'(periph.outQ.size()), 30'h2, "out count");
        periph.outQ.delete();
        dio_xfer(1'b1, 13'h0050, 1);
        check(periph.outQ[0], {15'h0122, 15'h0000}, "sum word");
        periph.inQ.push_back({15'h1234, 15'h4321});
        dio_xfer(1'b0, 13'h1FFE, 1);
        periph.outQ.delete();
        dio_xfer(1'b1, 13'h1FFE, 1);
        check(periph.outQ[0], {15'h1234, 15'h4321}, "top of store");
        periph.ackDelay = 0;
        $display("test read_back done");
    endtask

    task irq_service;
        int k;
        k = 0;
        irqVec = 13'h0070;
        irqReq = 1'b1;
        while (inService !== 1'b1 && k < 300) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check(30'(inService), 30'h1, "service entered");
        wait_strobe(15'h5555, "service routine word");
        irqReq = 1'b0;
        k = 0;
        while (inService !== 1'b0 && k < 300) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check(30'(inService), 30'h0, "service left");
        wait_strobe(15'h2AAA, "resumed accumulator");
        $display("test irq_service done");
    endtask

    // watchdog: whole run needs well under 20000 cycles
    initial begin
        #400000;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end

    // main sequence; auxIn is tied as no program reads it
    initial begin
        rst = 1'b1;
        irqReq = 1'b0;
        irqVec = 13'h0000;
        auxIn = 15'h0000;
        num_errors = 0;
        n_checks = 0;
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        load_program();
        run_main();
        read_back();
        irq_service();
        give_verdict();
    end
endmodule
